//--- src/pci_pkg.sv
// Package of constants and types for the pre-driver configuration instruction unit
package pci_pkg;
    localparam int PCI_NUM_UC = 4;
    localparam int PCI_NUM_HS = 5;
    localparam int PCI_NUM_LS = 7;
    localparam int PCI_NUM_OUT = 12;
    localparam int PCI_NUM_SCT = 3;
    localparam int PCI_NUM_CUR = 4;
    localparam int PCI_THR_W = 3;
    // Register addresses
    localparam logic [9:0] PCI_ADR_OUT_GRANT_A = 10'h184;
    localparam logic [9:0] PCI_ADR_OUT_GRANT_B = 10'h185;
    localparam logic [9:0] PCI_ADR_OUT_GRANT_C = 10'h186;
    localparam logic [9:0] PCI_ADR_OUT_GRANT_D = 10'h187;
    localparam logic [9:0] PCI_ADR_CUR_GRANT_1 = 10'h188;
    localparam logic [9:0] PCI_ADR_CUR_GRANT_2 = 10'h189;
    localparam logic [9:0] PCI_ADR_HS_VDS_THR = 10'h18A;
    localparam logic [9:0] PCI_ADR_HS_SRC_THR = 10'h18B;
    localparam logic [9:0] PCI_ADR_LS_VDS_THR_1 = 10'h18C;
    localparam logic [9:0] PCI_ADR_LS_VDS_THR_2 = 10'h18D;
    localparam logic [9:0] PCI_ADR_HS_SLEW = 10'h18E;
    localparam logic [9:0] PCI_ADR_LS_SLEW = 10'h18F;
    localparam logic [9:0] PCI_ADR_BOOST_LOW = 10'h1A1;
    localparam logic [9:0] PCI_ADR_BOOST_HIGH = 10'h1A2;
    localparam logic [15:0] PCI_REG_RESET = 16'h0000;
    // Output index: 0..4 high side 1..5, 5..11 low side 1..7
    localparam logic [3:0] PCI_OUT_LS7 = 4'hB;
    localparam logic [3:0] PCI_SCT_NONE = 4'hF;
    localparam logic [1:0] PCI_CUR_FOUR = 2'h3;
    typedef enum logic [3:0] {
        PCI_OP_NOP,
        PCI_OP_DFSCT,
        PCI_OP_STO,
        PCI_OP_STOS,
        PCI_OP_STSLEW,
        PCI_OP_STEOA,
        PCI_OP_BIAS,
        PCI_OP_STDCCTL,
        PCI_OP_CHTH,
        PCI_OP_SLFBK,
        PCI_OP_STFW,
        PCI_OP_DFCSCT,
        PCI_OP_STGN,
        PCI_OP_STOC
    } pci_op_t;
    typedef enum logic {
        PCI_DCDC_OFF,
        PCI_DCDC_ON
    } pci_dcdc_t;
endpackage : pci_pkg

//--- src/pci_grant_decode.sv
// Decodes per-microcore output and current feedback grants from grant registers
`timescale 1ns/1ps
module pci_grant_decode
    import pci_pkg::*;
(
    input wire logic [1:0] uc_sel,
    input wire logic [15:0] out_grant_a,
    input wire logic [15:0] out_grant_b,
    input wire logic [15:0] out_grant_c,
    input wire logic [15:0] out_grant_d,
    input wire logic [15:0] cur_grant_1,
    input wire logic [15:0] cur_grant_2,
    output logic [PCI_NUM_OUT-1:0] out_allow,
    output logic [PCI_NUM_CUR-1:0] cur_allow
);
    // One output grant word per microcore; current grants four bits each
    always_comb begin
        case (uc_sel)
            2'h0: out_allow = out_grant_a[PCI_NUM_OUT-1:0];
            2'h1: out_allow = out_grant_b[PCI_NUM_OUT-1:0];
            2'h2: out_allow = out_grant_c[PCI_NUM_OUT-1:0];
            default: out_allow = out_grant_d[PCI_NUM_OUT-1:0];
        endcase
        case (uc_sel)
            2'h0: cur_allow = cur_grant_1[3:0];
            2'h1: cur_allow = cur_grant_1[11:8];
            2'h2: cur_allow = cur_grant_2[3:0];
            default: cur_allow = cur_grant_2[11:8];
        endcase
    end
endmodule : pci_grant_decode

//--- src/pci_config_unit.sv
// Pre-driver and current block configuration instruction unit
`timescale 1ns/1ps
module pci_config_unit
    import pci_pkg::*;
#(
    parameter int NUM_UC = PCI_NUM_UC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [1:0] instr_uc,
    input wire logic [3:0] instr_op,
    input wire logic [15:0] instr_arg,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [PCI_NUM_CUR-1:0] current_feedback_raw,
    input wire logic dcdc_current_high,
    input wire logic dcdc_current_low,
    input wire logic [PCI_NUM_HS-1:0] hs_vds_cmp_raw,
    input wire logic [PCI_NUM_HS-1:0] hs_src_cmp_raw,
    input wire logic [PCI_NUM_LS-2:0] ls_vds_cmp_raw,
    output logic [15:0] reg_rdata,
    output logic instr_done,
    output logic [PCI_NUM_HS-1:0] hs_command,
    output logic [PCI_NUM_LS-1:0] ls_command,
    output logic [PCI_NUM_HS-1:0] hs_slew_max,
    output logic [15:0] hs_slew_rate,
    output logic [15:0] ls_slew_rate,
    output logic eoa_mode,
    output logic [PCI_NUM_HS-1:0] high_pullup_source,
    output logic [PCI_NUM_LS-2:0] low_pulldown_source,
    output logic dcdc_auto,
    output logic [1:0] drain_ref_boost,
    output logic auto_freewheel,
    output logic [PCI_NUM_HS-1:0] freewheel_partner,
    output logic [PCI_NUM_HS*PCI_THR_W-1:0] hs_vds_thr,
    output logic [PCI_NUM_HS*PCI_THR_W-1:0] hs_src_thr,
    output logic [(PCI_NUM_LS-1)*PCI_THR_W-1:0] ls_vds_thr,
    output logic [PCI_NUM_HS-1:0] hs_vds_fault,
    output logic [PCI_NUM_HS-1:0] hs_src_fault,
    output logic [PCI_NUM_LS-2:0] ls_vds_fault,
    output logic [2*PCI_NUM_CUR-1:0] amp_gain,
    output logic [PCI_NUM_CUR-1:0] offset_comp_en,
    output logic [NUM_UC*PCI_NUM_CUR-1:0] uc_current_feedback,
    output logic [NUM_UC*PCI_NUM_SCT*2-1:0] uc_current_shortcut
);
    initial begin
        if (NUM_UC != PCI_NUM_UC) begin
            $error("pci_config_unit: NUM_UC must be 4");
        end
    end

    typedef struct packed {
        logic [15:0] grant_a;
        logic [15:0] grant_b;
        logic [15:0] grant_c;
        logic [15:0] grant_d;
        logic [15:0] cgrant_1;
        logic [15:0] cgrant_2;
        logic [15:0] hs_vds;
        logic [15:0] hs_src;
        logic [15:0] ls_vds_1;
        logic [15:0] ls_vds_2;
        logic [15:0] hs_slew;
        logic [15:0] ls_slew;
        logic [15:0] boost_low;
        logic [15:0] boost_high;
        logic [15:0] rdata;
        logic done;
        logic [PCI_NUM_OUT-1:0] cmd;
        logic [PCI_NUM_OUT-1:0] slew_max;
        logic eoa;
        logic [PCI_NUM_OUT-1:0] bias;
        pci_dcdc_t dcdc;
        logic dcdc_on;
        logic [1:0] dref;
        logic afw;
        logic [2*PCI_NUM_CUR-1:0] gain;
        logic [PCI_NUM_CUR-1:0] ocomp;
        logic [PCI_NUM_UC*PCI_NUM_SCT*4-1:0] osct;
        logic [PCI_NUM_UC*PCI_NUM_SCT*2-1:0] csct;
        logic [PCI_NUM_UC*PCI_NUM_CUR-1:0] cfb;
        logic [PCI_NUM_OUT-1:0] fault;
        logic [PCI_NUM_HS-1:0] sfault;
        logic [PCI_NUM_HS-1:0] fwp;
    } pci_state_t;

    pci_state_t s_q;
    pci_state_t s_d;
    logic [PCI_NUM_OUT-1:0] out_allow;
    logic [PCI_NUM_UC*PCI_NUM_CUR-1:0] cur_allow_all;
    logic [PCI_NUM_OUT-1:0] sct_mask;
    logic [PCI_NUM_OUT-1:0] hit;
    logic [3:0] sct_idx;

    pci_grant_decode u_dec (
        .uc_sel(instr_uc),
        .out_grant_a(s_q.grant_a),
        .out_grant_b(s_q.grant_b),
        .out_grant_c(s_q.grant_c),
        .out_grant_d(s_q.grant_d),
        .cur_grant_1(s_q.cgrant_1),
        .cur_grant_2(s_q.cgrant_2),
        .out_allow(out_allow),
        .cur_allow()
    );

    // Current grants laid out as four bits per microcore
    assign cur_allow_all = {s_q.cgrant_2[11:8], s_q.cgrant_2[3:0],
                            s_q.cgrant_1[11:8], s_q.cgrant_1[3:0]};

    // Shortcut mask of the issuing microcore only
    always_comb begin
        sct_mask = '0;
        sct_idx = 4'h0;
        for (int k = 0; k < PCI_NUM_SCT; k++) begin
            sct_idx = s_q.osct[(int'(instr_uc)*PCI_NUM_SCT+k)*4 +: 4];
            if (sct_idx < 4'(PCI_NUM_OUT)) begin
                sct_mask[sct_idx] = 1'b1;
            end
        end
    end

    always_comb begin
        s_d = s_q;
        hit = '0;
        s_d.done = 1'b0;
        if (reg_wr) begin
            if (reg_addr == PCI_ADR_OUT_GRANT_A) begin
                s_d.grant_a = reg_wdata;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_B) begin
                s_d.grant_b = reg_wdata;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_C) begin
                s_d.grant_c = reg_wdata;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_D) begin
                s_d.grant_d = reg_wdata;
            end else if (reg_addr == PCI_ADR_CUR_GRANT_1) begin
                s_d.cgrant_1 = reg_wdata;
            end else if (reg_addr == PCI_ADR_CUR_GRANT_2) begin
                s_d.cgrant_2 = reg_wdata;
            end else if (reg_addr == PCI_ADR_HS_VDS_THR) begin
                s_d.hs_vds = reg_wdata;
            end else if (reg_addr == PCI_ADR_HS_SRC_THR) begin
                s_d.hs_src = reg_wdata;
            end else if (reg_addr == PCI_ADR_LS_VDS_THR_1) begin
                s_d.ls_vds_1 = reg_wdata;
            end else if (reg_addr == PCI_ADR_LS_VDS_THR_2) begin
                s_d.ls_vds_2 = reg_wdata;
            end else if (reg_addr == PCI_ADR_HS_SLEW) begin
                s_d.hs_slew = reg_wdata;
            end else if (reg_addr == PCI_ADR_LS_SLEW) begin
                s_d.ls_slew = reg_wdata;
            end else if (reg_addr == PCI_ADR_BOOST_LOW) begin
                s_d.boost_low = reg_wdata;
            end else if (reg_addr == PCI_ADR_BOOST_HIGH) begin
                s_d.boost_high = reg_wdata;
            end
        end
        if (instr_valid) begin
            s_d.done = 1'b1;
            case (pci_op_t'(instr_op))
                PCI_OP_DFSCT: begin
                    s_d.osct[int'(instr_uc)*PCI_NUM_SCT*4 +: 12] = instr_arg[11:0];
                end
                PCI_OP_STO: begin
                    if (instr_arg[3:0] < 4'(PCI_NUM_OUT)) begin
                        hit[instr_arg[3:0]] = 1'b1;
                    end
                    hit = hit & out_allow;
                    s_d.cmd = (s_q.cmd & ~hit) | (hit & {PCI_NUM_OUT{instr_arg[4]}});
                end
                PCI_OP_STOS: begin
                    hit = sct_mask & out_allow;
                    s_d.cmd = (s_q.cmd & ~hit) | (hit & {PCI_NUM_OUT{instr_arg[4]}});
                end
                PCI_OP_STSLEW: begin
                    s_d.slew_max = {PCI_NUM_OUT{instr_arg[0]}};
                end
                PCI_OP_STEOA: begin
                    s_d.eoa = instr_arg[0];
                end
                PCI_OP_BIAS: begin
                    hit = instr_arg[PCI_NUM_OUT-1:0] & out_allow;
                    hit[PCI_OUT_LS7] = 1'b0;
                    s_d.bias = (s_q.bias & ~hit) | (hit & {PCI_NUM_OUT{instr_arg[15]}});
                end
                PCI_OP_STDCCTL: begin
                    s_d.dcdc = instr_arg[0] ? PCI_DCDC_ON : PCI_DCDC_OFF;
                end
                PCI_OP_CHTH: begin
                    if (instr_arg[9:8] == 2'h0) begin
                        s_d.hs_vds[int'(instr_arg[7:5])*PCI_THR_W +: PCI_THR_W] = instr_arg[2:0];
                    end else if (instr_arg[9:8] == 2'h1) begin
                        s_d.hs_src[int'(instr_arg[7:5])*PCI_THR_W +: PCI_THR_W] = instr_arg[2:0];
                    end else if (instr_arg[9:8] == 2'h2) begin
                        s_d.ls_vds_1[int'(instr_arg[7:5])*PCI_THR_W +: PCI_THR_W] = instr_arg[2:0];
                    end else begin
                        s_d.ls_vds_2[int'(instr_arg[7:5])*PCI_THR_W +: PCI_THR_W] = instr_arg[2:0];
                    end
                end
                PCI_OP_SLFBK: begin
                    s_d.dref = instr_arg[1:0];
                end
                PCI_OP_STFW: begin
                    s_d.afw = instr_arg[0];
                end
                PCI_OP_DFCSCT: begin
                    s_d.csct[int'(instr_uc)*PCI_NUM_SCT*2 +: 6] = instr_arg[5:0];
                end
                PCI_OP_STGN: begin
                    s_d.gain = instr_arg[7:0];
                end
                PCI_OP_STOC: begin
                    s_d.ocomp = instr_arg[3:0];
                end
                default: begin
                    s_d.done = 1'b0;
                end
            endcase
        end
        // Hysteretic regulation of low side seven from current block four
        s_d.dcdc_on = s_q.dcdc_on;
        if (s_q.dcdc == PCI_DCDC_ON) begin
            if (dcdc_current_high) begin
                s_d.dcdc_on = 1'b0;
            end else if (dcdc_current_low) begin
                s_d.dcdc_on = 1'b1;
            end
            s_d.cmd[PCI_OUT_LS7] = s_d.dcdc_on;
        end else begin
            s_d.dcdc_on = 1'b0;
        end
        // Commanded partner of each high side, in order HS1..HS5: LS5, LS6, LS7, HS5, LS4
        s_d.fwp = s_d.afw ? {s_d.cmd[8], s_d.cmd[4], s_d.cmd[11], s_d.cmd[10], s_d.cmd[9]}
                          : '0;
        s_d.cfb = {NUM_UC{current_feedback_raw}} & cur_allow_all;
        s_d.fault[PCI_NUM_HS-1:0] = hs_vds_cmp_raw;
        s_d.sfault = hs_src_cmp_raw;
        s_d.fault[PCI_NUM_OUT-2:PCI_NUM_HS] = ls_vds_cmp_raw;
        s_d.fault[PCI_OUT_LS7] = 1'b0;
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == PCI_ADR_OUT_GRANT_A) begin
                s_d.rdata = s_q.grant_a;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_B) begin
                s_d.rdata = s_q.grant_b;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_C) begin
                s_d.rdata = s_q.grant_c;
            end else if (reg_addr == PCI_ADR_OUT_GRANT_D) begin
                s_d.rdata = s_q.grant_d;
            end else if (reg_addr == PCI_ADR_CUR_GRANT_1) begin
                s_d.rdata = s_q.cgrant_1;
            end else if (reg_addr == PCI_ADR_CUR_GRANT_2) begin
                s_d.rdata = s_q.cgrant_2;
            end else if (reg_addr == PCI_ADR_HS_VDS_THR) begin
                s_d.rdata = s_q.hs_vds;
            end else if (reg_addr == PCI_ADR_HS_SRC_THR) begin
                s_d.rdata = s_q.hs_src;
            end else if (reg_addr == PCI_ADR_LS_VDS_THR_1) begin
                s_d.rdata = s_q.ls_vds_1;
            end else if (reg_addr == PCI_ADR_LS_VDS_THR_2) begin
                s_d.rdata = s_q.ls_vds_2;
            end else if (reg_addr == PCI_ADR_HS_SLEW) begin
                s_d.rdata = s_q.hs_slew;
            end else if (reg_addr == PCI_ADR_LS_SLEW) begin
                s_d.rdata = s_q.ls_slew;
            end else if (reg_addr == PCI_ADR_BOOST_LOW) begin
                s_d.rdata = s_q.boost_low;
            end else if (reg_addr == PCI_ADR_BOOST_HIGH) begin
                s_d.rdata = s_q.boost_high;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.osct <= {(PCI_NUM_UC*PCI_NUM_SCT){PCI_SCT_NONE}};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign instr_done = s_q.done;
    assign hs_command = s_q.cmd[PCI_NUM_HS-1:0];
    assign ls_command = s_q.cmd[PCI_NUM_OUT-1:PCI_NUM_HS];
    assign hs_slew_max = s_q.slew_max[PCI_NUM_HS-1:0];
    assign hs_slew_rate = s_q.hs_slew;
    assign ls_slew_rate = s_q.ls_slew;
    assign eoa_mode = s_q.eoa;
    assign high_pullup_source = s_q.bias[PCI_NUM_HS-1:0];
    assign low_pulldown_source = s_q.bias[PCI_NUM_OUT-2:PCI_NUM_HS];
    assign dcdc_auto = (s_q.dcdc == PCI_DCDC_ON);
    assign drain_ref_boost = s_q.dref;
    assign auto_freewheel = s_q.afw;
    assign freewheel_partner = s_q.fwp;
    assign hs_vds_thr = s_q.hs_vds[14:0];
    assign hs_src_thr = s_q.hs_src[14:0];
    assign ls_vds_thr = {s_q.ls_vds_2[8:0], s_q.ls_vds_1[8:0]};
    assign hs_vds_fault = s_q.fault[PCI_NUM_HS-1:0];
    assign hs_src_fault = s_q.sfault;
    assign ls_vds_fault = s_q.fault[PCI_NUM_OUT-2:PCI_NUM_HS];
    assign amp_gain = s_q.gain;
    assign offset_comp_en = s_q.ocomp;
    assign uc_current_feedback = s_q.cfb;
    assign uc_current_shortcut = s_q.csct;
endmodule : pci_config_unit

//--- dv/pci_config_unit_properties.sv
// Checker of instruction timing and configuration effects at the unit's ports
`timescale 1ns/1ps
module pci_config_unit_properties
    import pci_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [15:0] instr_arg,
    input wire logic dcdc_current_high,
    input wire logic dcdc_current_low,
    input wire logic instr_done,
    input wire logic [PCI_NUM_HS-1:0] hs_command,
    input wire logic [PCI_NUM_LS-1:0] ls_command,
    input wire logic [PCI_NUM_HS-1:0] hs_slew_max,
    input wire logic eoa_mode,
    input wire logic dcdc_auto,
    input wire logic [1:0] drain_ref_boost,
    input wire logic auto_freewheel,
    input wire logic [2*PCI_NUM_CUR-1:0] amp_gain,
    input wire logic [PCI_NUM_CUR-1:0] offset_comp_en
);
    logic go;
    assign go = clk_en && instr_valid;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    a_done_next: assert property (go && instr_op inside {[4'h1:4'hD]} |=> instr_done)
        else $error("instruction gave no done pulse");
    a_done_idle: assert property (clk_en && !instr_valid |=> !instr_done)
        else $error("done pulse without instruction");
    a_cmd_hold: assert property (clk_en && !instr_valid |=> $stable(hs_command))
        else $error("high side command moved without instruction");
    a_slew_force: assert property (go && instr_op == PCI_OP_STSLEW
        |=> hs_slew_max == {PCI_NUM_HS{$past(instr_arg[0])}}) else $error("slew force wrong");
    a_eoa_mode: assert property (go && instr_op == PCI_OP_STEOA
        |=> eoa_mode == $past(instr_arg[0])) else $error("end of actuation mode wrong");
    a_dcdc_mode: assert property (go && instr_op == PCI_OP_STDCCTL
        |=> dcdc_auto == $past(instr_arg[0])) else $error("dc-dc mode wrong");
    a_dcdc_regulate: assert property (dcdc_auto && clk_en && !instr_valid
        && (dcdc_current_high || dcdc_current_low) |=> ls_command[6] == !$past(dcdc_current_high))
        else $error("automatic low side seven wrong");
    a_drain_ref: assert property (go && instr_op == PCI_OP_SLFBK
        |=> drain_ref_boost == $past(instr_arg[1:0])) else $error("drain reference wrong");
    a_fw_mode: assert property (go && instr_op == PCI_OP_STFW
        |=> auto_freewheel == $past(instr_arg[0])) else $error("freewheel mode wrong");
    a_gain_set: assert property (go && instr_op == PCI_OP_STGN
        |=> amp_gain == $past(instr_arg[7:0])) else $error("amplifier gain wrong");
    a_offset_set: assert property (go && instr_op == PCI_OP_STOC
        |=> offset_comp_en == $past(instr_arg[3:0])) else $error("offset enable wrong");
endmodule : pci_config_unit_properties

bind pci_config_unit pci_config_unit_properties i_props (.core_clk, .srst, .clk_en,
    .instr_valid, .instr_op, .instr_arg, .dcdc_current_high, .dcdc_current_low, .instr_done,
    .hs_command, .ls_command, .hs_slew_max, .eoa_mode, .dcdc_auto, .drain_ref_boost,
    .auto_freewheel, .amp_gain, .offset_comp_en);

//--- dv/pci_seq_model.sv
// Behavioural microcore sequencer issuing configuration instructions
`timescale 1ns/1ps
module pci_seq_model (
    input wire logic core_clk,
    output logic instr_valid,
    output logic [1:0] instr_uc,
    output logic [3:0] instr_op,
    output logic [15:0] instr_arg
);
    initial begin
        instr_valid = 1'b0;
        instr_uc = 2'h0;
        instr_op = 4'h0;
        instr_arg = 16'h0000;
    end
    // Entered just after an edge; the instruction is taken at the next edge
    task automatic issue(input logic [1:0] uc, input logic [3:0] op, input logic [15:0] arg);
        instr_valid = 1'b1;
        instr_uc = uc;
        instr_op = op;
        instr_arg = arg;
        @(posedge core_clk);
        #1;
    endtask : issue
    // Released operand lines show the inverse of the last value
    task automatic idle();
        instr_valid = 1'b0;
        instr_arg = ~instr_arg;
    endtask : idle
endmodule : pci_seq_model

//--- dv/pci_config_unit_bench.sv
// Self-checking bench of the configuration instruction unit
`timescale 1ns/1ps
module pci_config_unit_bench
    import pci_pkg::*;
;
    logic core_clk, srst, clk_en, instr_valid, reg_wr, reg_rd, dcdc_current_high;
    logic dcdc_current_low, instr_done, eoa_mode, dcdc_auto, auto_freewheel;
    logic [1:0] instr_uc, drain_ref_boost;
    logic [3:0] instr_op, current_feedback_raw, offset_comp_en;
    logic [15:0] instr_arg, reg_wdata, reg_rdata, hs_slew_rate, ls_slew_rate, rdv;
    logic [4:0] freewheel_partner, hs_src_fault;
    logic [9:0] reg_addr;
    logic [4:0] hs_vds_cmp_raw, hs_src_cmp_raw, hs_command, hs_slew_max, high_pullup_source;
    logic [4:0] hs_vds_fault;
    logic [5:0] ls_vds_cmp_raw, low_pulldown_source, ls_vds_fault;
    logic [6:0] ls_command;
    logic [14:0] hs_vds_thr;
    logic [7:0] amp_gain;
    logic [15:0] uc_current_feedback;
    logic [23:0] uc_current_shortcut;
    logic [9:0] regs [14] = '{10'h184, 10'h185, 10'h186, 10'h187, 10'h188, 10'h189, 10'h18A,
        10'h18B, 10'h18C, 10'h18D, 10'h18E, 10'h18F, 10'h1A1, 10'h1A2};
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    pci_seq_model i_seq (.core_clk, .instr_valid, .instr_uc, .instr_op, .instr_arg);
    pci_config_unit i_dut (.core_clk, .srst, .clk_en, .instr_valid, .instr_uc, .instr_op,
        .instr_arg, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .current_feedback_raw,
        .dcdc_current_high, .dcdc_current_low, .hs_vds_cmp_raw, .hs_src_cmp_raw,
        .ls_vds_cmp_raw, .reg_rdata, .instr_done, .hs_command, .ls_command, .hs_slew_max,
        .hs_slew_rate, .ls_slew_rate, .eoa_mode, .high_pullup_source, .low_pulldown_source,
        .dcdc_auto, .drain_ref_boost, .auto_freewheel, .freewheel_partner, .hs_vds_thr,
        .hs_src_thr(), .ls_vds_thr(), .hs_vds_fault, .hs_src_fault, .ls_vds_fault, .amp_gain,
        .offset_comp_en, .uc_current_feedback, .uc_current_shortcut);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        reg_wr = 1'b0;
        step();
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        step();
        reg_rd = 1'b0;
        d = reg_rdata;
        step();
    endtask : rd
    task automatic ins(input logic [1:0] uc, input logic [3:0] op, input logic [15:0] arg);
        i_seq.issue(uc, op, arg);
        i_seq.idle();
        step();
    endtask : ins
    initial begin
        {srst, clk_en, reg_wr, reg_rd, dcdc_current_high, dcdc_current_low} = 6'h30;
        {reg_addr, reg_wdata, current_feedback_raw} = 30'h0;
        {hs_vds_cmp_raw, hs_src_cmp_raw, ls_vds_cmp_raw} = 16'h0;
        repeat (20) @(posedge core_clk);
        #1;
        srst = 1'b0;
        foreach (regs[i]) begin
            rd(regs[i], rdv);
            chk(rdv, 16'h0000);
            wr(regs[i], {6'h2A, regs[i]});
            rd(regs[i], rdv);
            chk(rdv, {6'h2A, regs[i]});
        end
        wr(10'h190, 16'hFFFF);
        rd(10'h190, rdv);
        chk(rdv, 16'h0000);
        $display("test registers done");
        wr(PCI_ADR_OUT_GRANT_A, 16'h0001);
        wr(PCI_ADR_OUT_GRANT_B, 16'h0800);
        i_seq.issue(2'h0, PCI_OP_STO, 16'h0010);
        chk(hs_command, 5'h01);
        chk(instr_done, 1'b1);
        i_seq.idle();
        step();
        chk(instr_done, 1'b0);
        ins(2'h0, PCI_OP_STO, 16'h0011);
        chk(hs_command, 5'h01);
        ins(2'h1, PCI_OP_STO, 16'h001B);
        chk(ls_command, 7'h40);
        wr(PCI_ADR_OUT_GRANT_A, 16'h0FFF);
        i_seq.issue(2'h0, PCI_OP_DFSCT, 16'h0F52);
        i_seq.issue(2'h1, PCI_OP_DFSCT, 16'h0210);
        ins(2'h0, PCI_OP_STOS, 16'h0010);
        chk({hs_command, ls_command}, 12'h2C1);
        ins(2'h0, PCI_OP_STOS, 16'h0000);
        chk({hs_command, ls_command}, 12'h0C0);
        $display("test actuation done");
        ins(2'h0, PCI_OP_STSLEW, 16'h0001);
        chk(hs_slew_max, 5'h1F);
        chk(hs_slew_rate, 16'hA98E);
        chk(ls_slew_rate, 16'hA98F);
        ins(2'h0, PCI_OP_STEOA, 16'h0001);
        chk(eoa_mode, 1'b1);
        ins(2'h0, PCI_OP_BIAS, 16'h883F);
        chk({high_pullup_source, low_pulldown_source}, 11'h7C1);
        ins(2'h0, PCI_OP_BIAS, 16'h0003);
        chk(high_pullup_source, 5'h1C);
        ins(2'h1, PCI_OP_BIAS, 16'h8040);
        chk(low_pulldown_source, 6'h01);
        ins(2'h0, PCI_OP_STDCCTL, 16'h0001);
        chk(dcdc_auto, 1'b1);
        dcdc_current_high = 1'b1;
        repeat (2) step();
        chk(ls_command[6], 1'b0);
        {dcdc_current_low, dcdc_current_high} = 2'b10;
        repeat (2) step();
        chk(ls_command[6], 1'b1);
        dcdc_current_low = 1'b0;
        ins(2'h0, PCI_OP_STDCCTL, 16'h0000);
        ins(2'h1, PCI_OP_STO, 16'h000B);
        chk(ls_command[6], 1'b0);
        $display("test drive config done");
        wr(PCI_ADR_HS_VDS_THR, 16'h0000);
        wr(PCI_ADR_LS_VDS_THR_2, 16'h0000);
        ins(2'h2, PCI_OP_CHTH, 16'h0045);
        chk(hs_vds_thr[8:6], 3'h5);
        ins(2'h3, PCI_OP_CHTH, 16'h0327);
        rd(PCI_ADR_LS_VDS_THR_2, rdv);
        chk(rdv, 16'h0038);
        rd(PCI_ADR_HS_VDS_THR, rdv);
        chk(rdv, 16'h0140);
        {hs_vds_cmp_raw, hs_src_cmp_raw, ls_vds_cmp_raw} = {5'h15, 5'h0B, 6'h2A};
        repeat (2) step();
        chk({hs_vds_fault, ls_vds_fault}, {5'h15, 6'h2A});
        chk(hs_src_fault, 5'h0B);
        ins(2'h1, PCI_OP_SLFBK, 16'h0002);
        chk(drain_ref_boost, 2'h2);
        ins(2'h2, PCI_OP_STFW, 16'h0001);
        chk(auto_freewheel, 1'b1);
        ins(2'h0, PCI_OP_STO, 16'h0014);
        chk(freewheel_partner, 5'h08);
        ins(2'h3, PCI_OP_STGN, 16'h00E4);
        chk(amp_gain, 8'hE4);
        ins(2'h3, PCI_OP_STOC, 16'h000A);
        chk(offset_comp_en, 4'hA);
        ins(2'h2, PCI_OP_DFCSCT, 16'h0039);
        chk(uc_current_shortcut[17:12], 6'h39);
        wr(PCI_ADR_CUR_GRANT_1, 16'h0305);
        current_feedback_raw = 4'hF;
        repeat (2) step();
        chk(uc_current_feedback[7:0], 8'h35);
        ins(2'h0, 4'hE, 16'h0000);
        chk(instr_done, 1'b0);
        clk_en = 1'b0;
        ins(2'h0, PCI_OP_STEOA, 16'h0000);
        chk(eoa_mode, 1'b1);
        clk_en = 1'b1;
        $display("test monitor config done");
        end_sim();
    end
endmodule : pci_config_unit_bench
